// *** core/usl_defines.vh ***
// Register offsets, field positions, reset values and encodings
`ifndef USL_DEFINES_VH
`define USL_DEFINES_VH
`define USL_OFF_DATA 3'h0
`define USL_OFF_IEN 3'h1
`define USL_OFF_FIFO_SETUP 3'h2
`define USL_OFF_FRAME 3'h3
`define USL_OFF_HSO 3'h4
`define USL_OFF_LINE 3'h5
`define USL_OFF_HSI 3'h6
`define USL_OFF_SCRATCH 3'h7
`define USL_FS_ENABLE 0
`define USL_FS_RXCLR 1
`define USL_FS_TXCLR 2
`define USL_FS_PINMODE 3
`define USL_FRAME_DIVSEL 7
`define USL_FRAME_BREAK 6
`define USL_RST_FRAME 8'h00
`define USL_RST_HSO 8'h00
`define USL_RST_DIV 16'h0001
`define USL_ID_LINE 4'h6
`define USL_ID_RXDATA 4'h4
`define USL_ID_RXTIMEOUT 4'hC
`define USL_ID_TXEMPTY 4'h2
`define USL_ID_MODEM 4'h0
`define USL_FIFO_DEPTH 16
`define USL_TRIG_1 5'h01
`define USL_TRIG_4 5'h04
`define USL_TRIG_8 5'h08
`define USL_TRIG_14 5'h0E
`define USL_TIMEOUT_CHARS 4
`endif

// *** core/usl_char_fifo.v ***
// Character FIFO with flush, data plus three error flag bits
`timescale 1ns/10ps
`include "usl_defines.vh"
module usl_char_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire flush_i,
    input wire one_deep_i,
    input wire push_i,
    input wire [WIDTH-1:0] push_data_i,
    input wire pop_i,
    output wire [WIDTH-1:0] head_o,
    output wire [AW:0] count_o,
    output wire full_o,
    output wire err_any_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire [AW:0] cap;
    wire do_push;
    wire do_pop;
    reg err_any;
    integer k;
    assign cap = one_deep_i ? {{AW{1'b0}}, 1'b1} : DEPTH[AW:0];
    assign full_o = (cnt_q >= cap);
    assign do_pop = pop_i && (cnt_q != {(AW+1){1'b0}});
    assign do_push = push_i && (!full_o || do_pop);
    assign head_o = mem[rd_q];
    assign count_o = cnt_q;
    assign err_any_o = err_any;
    // Any stored character holding an error flag
    always @* begin
        err_any = 1'b0;
        for (k = 0; k < DEPTH; k = k + 1) begin
            if ((k[AW:0] - {1'b0, rd_q}) % DEPTH < cnt_q &&
                |mem[k][WIDTH-1:WIDTH-3]) begin
                err_any = 1'b1;
            end
        end
    end
    always @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_q] <= push_data_i;
        end
    end
    always @(posedge clk_i) begin
        if (!reset_n_i || flush_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// *** core/usl_sync.v ***
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module usl_sync #(
    parameter WIDTH = 5
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q;
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            meta_q <= {WIDTH{1'b1}};
            sync_o <= {WIDTH{1'b1}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// *** core/usl_port.v ***
// Serial port control and status: registers, FIFOs, serial engines
`timescale 1ns/10ps
`include "usl_defines.vh"
// How it works
// - Identification shows highest pending source: line, rx, tx, modem.
// - FIFO setup bit 0 enables both FIFOs, else one-character buffers.
// - FIFO setup bit 1 empties the receive FIFO.
// - FIFO setup bit 2 empties transmit FIFO, shifter untouched.
// - FIFO setup bit 3 switches ready pins to mode 1 signalling when bit 0 enables the FIFOs.
// - FIFO setup bits 7:6 pick receive trigger 1, 4, 8 or 14.
// - Frame bits 1:0 give 5 to 8 data bits both directions.
// - Frame bit 7 maps offsets 0 and 1 to divisor bytes.
// - Line bit 5 is one when transmit side accepts a character.
// - Line bit 6 is one when holding store and shifter empty.
// - Line bit 7 is one with FIFOs enabled while any stored character has errors.
// - Handshake bit 2 sets on ring indicator trailing edge.
// - Handshake bit 3 sets when carrier detect changed since read.
// - Handshake bits 4 to 7 show CTS, DSR, RI, carrier detect.
// - Identification bit 0 low when pending; bits 7:6 show FIFOs.
// - Divisor latch is a 16-bit bit rate divider.
module usl_port #(
    parameter DEPTH = `USL_FIFO_DEPTH,
    parameter AW = 4
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire [2:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    output reg irq_o,
    input wire rxd_i,
    input wire cts_n_i,
    input wire dsr_n_i,
    input wire ri_n_i,
    input wire dcd_n_i,
    output reg txd_o,
    output reg dtr_n_o,
    output reg rts_n_o,
    output reg receive_ready_pin_n_o,
    output reg transmit_ready_pin_n_o
);
    reg [7:0] frame_q;
    reg [7:0] hso_q;
    reg [7:0] scratch_q;
    reg [7:0] ien_q;
    reg [15:0] div_q;
    reg fifo_en_q;
    reg pin_mode_q;
    reg [1:0] trig_q;
    reg [3:0] line_err_q;
    reg [3:0] hsi_delta_q;
    reg [3:0] hsi_prev_q;
    reg thr_irq_q;
    wire [4:0] pins_s;
    wire [3:0] hsi_now;
    wire divsel;
    wire rd_line;
    wire rd_hsi;
    wire rd_data;
    wire wr_data;
    wire rd_id;
    wire [10:0] rx_head;
    wire [AW:0] rx_cnt;
    wire rx_full;
    wire rx_err_any;
    wire [10:0] tx_head;
    wire [AW:0] tx_cnt;
    wire tx_full;
    reg rx_push;
    reg [10:0] rx_word;
    reg tx_pop;
    reg [15:0] bdiv_q;
    reg [3:0] tick16_q;
    reg bit_tick;
    reg rx_sample;
    reg [2:0] rx_st_q;
    reg [3:0] rx_ph_q;
    reg [3:0] rx_bit_q;
    reg [7:0] rx_sh_q;
    reg rx_par_q;
    reg [2:0] tx_st_q;
    reg [3:0] tx_bit_q;
    reg [7:0] tx_sh_q;
    reg tx_par_q;
    reg [3:0] tx_ph_q;
    reg [9:0] idle_q;
    reg timeout_q;
    reg [4:0] trig_lvl;
    reg [3:0] id_code;
    reg pend;
    wire [3:0] nbits;
    localparam ST_IDLE = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_DATA = 3'd2;
    localparam ST_PAR = 3'd3;
    localparam ST_STOP = 3'd4;
    usl_sync #(.WIDTH(5)) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i({rxd_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
        .sync_o(pins_s)
    );
    assign hsi_now = ~pins_s[3:0];
    assign divsel = frame_q[`USL_FRAME_DIVSEL];
    assign rd_line = rd_i && addr_i == `USL_OFF_LINE;
    assign rd_hsi = rd_i && addr_i == `USL_OFF_HSI;
    assign rd_id = rd_i && addr_i == `USL_OFF_FIFO_SETUP;
    assign rd_data = rd_i && addr_i == `USL_OFF_DATA && !divsel;
    assign wr_data = wr_i && addr_i == `USL_OFF_DATA && !divsel;
    assign nbits = {2'b00, frame_q[1:0]} + 4'd5;
    usl_char_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_rx (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .flush_i(wr_i && addr_i == `USL_OFF_FIFO_SETUP &&
                 (wdata_i[`USL_FS_RXCLR] ||
                  wdata_i[`USL_FS_ENABLE] != fifo_en_q)),
        .one_deep_i(!fifo_en_q),
        .push_i(rx_push),
        .push_data_i(rx_word),
        .pop_i(rd_data),
        .head_o(rx_head),
        .count_o(rx_cnt),
        .full_o(rx_full),
        .err_any_o(rx_err_any)
    );
    usl_char_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_tx (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .flush_i(wr_i && addr_i == `USL_OFF_FIFO_SETUP &&
                 (wdata_i[`USL_FS_TXCLR] ||
                  wdata_i[`USL_FS_ENABLE] != fifo_en_q)),
        .one_deep_i(!fifo_en_q),
        .push_i(wr_data),
        .push_data_i({3'b000, wdata_i}),
        .pop_i(tx_pop),
        .head_o(tx_head),
        .count_o(tx_cnt),
        .full_o(tx_full),
        .err_any_o()
    );
    // Register writes
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            frame_q <= `USL_RST_FRAME;
            hso_q <= `USL_RST_HSO;
            scratch_q <= 8'h00;
            ien_q <= 8'h00;
            div_q <= `USL_RST_DIV;
            fifo_en_q <= 1'b0;
            pin_mode_q <= 1'b0;
            trig_q <= 2'b00;
        end else if (wr_i) begin
            case (addr_i)
                `USL_OFF_DATA: begin
                    if (divsel) begin
                        div_q[7:0] <= wdata_i;
                    end
                end
                `USL_OFF_IEN: begin
                    if (divsel) begin
                        div_q[15:8] <= wdata_i;
                    end else begin
                        ien_q <= {4'h0, wdata_i[3:0]};
                    end
                end
                `USL_OFF_FIFO_SETUP: begin
                    fifo_en_q <= wdata_i[`USL_FS_ENABLE];
                    pin_mode_q <= wdata_i[`USL_FS_PINMODE];
                    trig_q <= wdata_i[7:6];
                end
                `USL_OFF_FRAME: frame_q <= wdata_i;
                `USL_OFF_HSO: hso_q <= {3'b000, wdata_i[4:0]};
                `USL_OFF_SCRATCH: scratch_q <= wdata_i;
                default: begin
                end
            endcase
        end
    end
    // baud divider, 16 ticks per bit
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            bdiv_q <= 16'h0000;
            rx_sample <= 1'b0;
        end else begin
            rx_sample <= 1'b0;
            if (bdiv_q + 16'h0001 >= div_q) begin
                bdiv_q <= 16'h0000;
                rx_sample <= 1'b1;
            end else begin
                bdiv_q <= bdiv_q + 16'h0001;
            end
        end
    end
    // receiver with parity, stick and stop checks
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            rx_st_q <= ST_IDLE;
            rx_ph_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_par_q <= 1'b0;
            rx_push <= 1'b0;
            rx_word <= 11'h000;
        end else begin
            rx_push <= 1'b0;
            if (rx_sample) begin
                rx_ph_q <= rx_ph_q + 4'h1;
                case (rx_st_q)
                    ST_IDLE: begin
                        rx_ph_q <= 4'h0;
                        if (!pins_s[4]) begin
                            rx_st_q <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (rx_ph_q == 4'h7) begin
                            rx_ph_q <= 4'h0;
                            rx_bit_q <= 4'h0;
                            rx_sh_q <= 8'h00;
                            rx_par_q <= 1'b0;
                            rx_st_q <= pins_s[4] ? ST_IDLE : ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (rx_ph_q == 4'hF) begin
                            rx_sh_q[rx_bit_q[2:0]] <= pins_s[4];
                            rx_par_q <= rx_par_q ^ pins_s[4];
                            rx_bit_q <= rx_bit_q + 4'h1;
                            if (rx_bit_q + 4'h1 == nbits) begin
                                rx_st_q <= frame_q[3] ? ST_PAR : ST_STOP;
                            end
                        end
                    end
                    ST_PAR: begin
                        if (rx_ph_q == 4'hF) begin
                            rx_par_q <= frame_q[5] ?
                                (pins_s[4] != !frame_q[4]) :
                                (rx_par_q ^ pins_s[4] ^ !frame_q[4]);
                            rx_st_q <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (rx_ph_q == 4'hF) begin
                            rx_push <= 1'b1;
                            rx_word <= {
                                rx_sh_q == 8'h00 && !pins_s[4],
                                !pins_s[4],
                                frame_q[3] && rx_par_q,
                                rx_sh_q};
                            rx_st_q <= ST_IDLE;
                        end
                    end
                    default: rx_st_q <= ST_IDLE;
                endcase
            end
        end
    end
    always @* begin
        bit_tick = rx_sample && tx_ph_q == 4'hF;
    end
    // transmitter with break and extra stop bits
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            tx_st_q <= ST_IDLE;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 8'h00;
            tx_par_q <= 1'b0;
            tx_ph_q <= 4'h0;
            tx_pop <= 1'b0;
            txd_o <= 1'b1;
        end else begin
            tx_pop <= 1'b0;
            if (rx_sample) begin
                tx_ph_q <= tx_ph_q + 4'h1;
            end
            txd_o <= frame_q[`USL_FRAME_BREAK] ? 1'b0 :
                     (tx_st_q == ST_START) ? 1'b0 :
                     (tx_st_q == ST_DATA) ? tx_sh_q[0] :
                     (tx_st_q == ST_PAR) ? tx_par_q : 1'b1;
            case (tx_st_q)
                ST_IDLE: begin
                    if (tx_cnt != {(AW+1){1'b0}} && !tx_pop) begin
                        tx_sh_q <= tx_head[7:0];
                        tx_par_q <= ^(tx_head[7:0] &
                                    (8'hFF >> (4'd8 - nbits)));
                        tx_pop <= 1'b1;
                        tx_ph_q <= 4'h0;
                        tx_st_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (bit_tick) begin
                        tx_bit_q <= 4'h0;
                        tx_par_q <= frame_q[5] ? !frame_q[4] :
                                    (tx_par_q ^ !frame_q[4]);
                        tx_st_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (bit_tick) begin
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (tx_bit_q + 4'h1 == nbits) begin
                            tx_bit_q <= 4'h0;
                            tx_st_q <= frame_q[3] ? ST_PAR : ST_STOP;
                        end
                    end
                end
                ST_PAR: begin
                    if (bit_tick) begin
                        tx_st_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (bit_tick) begin
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (!frame_q[2] || tx_bit_q == 4'h1) begin
                            tx_st_q <= ST_IDLE;
                        end
                    end
                end
                default: tx_st_q <= ST_IDLE;
            endcase
        end
    end
    // Receive timeout after four idle character times
    always @(posedge clk_i) begin
        if (!reset_n_i || rd_data || rx_push ||
            rx_cnt == {(AW+1){1'b0}} || !fifo_en_q) begin
            idle_q <= 10'h000;
            timeout_q <= 1'b0;
        end else if (bit_tick && !timeout_q) begin
            idle_q <= idle_q + 10'h001;
            if (idle_q == 10'd10 * `USL_TIMEOUT_CHARS) begin
                timeout_q <= 1'b1;
            end
        end
    end
    // Sticky status flags; set wins over the read clear
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            line_err_q <= 4'h0;
            hsi_delta_q <= 4'h0;
            hsi_prev_q <= 4'h0;
            thr_irq_q <= 1'b0;
        end else begin
            hsi_prev_q <= hsi_now;
            line_err_q <= (rd_line ? 4'h0 : line_err_q) |
                ({4{rx_push}} & {rx_word[10:8],
                 rx_full && !rd_data});
            hsi_delta_q[3] <= (rd_hsi ? 1'b0 : hsi_delta_q[3]) |
                (hsi_now[3] ^ hsi_prev_q[3]);
            hsi_delta_q[2] <= (rd_hsi ? 1'b0 : hsi_delta_q[2]) |
                (hsi_prev_q[2] && !hsi_now[2]);
            hsi_delta_q[1:0] <= (rd_hsi ? 2'b00 : hsi_delta_q[1:0]) |
                (hsi_now[1:0] ^ hsi_prev_q[1:0]);
            if (tx_cnt == {{AW{1'b0}}, 1'b1} && tx_pop && !wr_data) begin
                thr_irq_q <= 1'b1;
            end else if (wr_data || (rd_id && id_code ==
                         `USL_ID_TXEMPTY)) begin
                thr_irq_q <= 1'b0;
            end
        end
    end
    always @* begin
        case (trig_q)
            2'b00: trig_lvl = `USL_TRIG_1;
            2'b01: trig_lvl = `USL_TRIG_4;
            2'b10: trig_lvl = `USL_TRIG_8;
            default: trig_lvl = `USL_TRIG_14;
        endcase
    end
    always @* begin
        pend = 1'b1;
        if (ien_q[2] && |line_err_q) begin
            id_code = `USL_ID_LINE;
        end else if (ien_q[0] && fifo_en_q && timeout_q) begin
            id_code = `USL_ID_RXTIMEOUT;
        end else if (ien_q[0] && ((fifo_en_q &&
                     rx_cnt >= trig_lvl) ||
                     (!fifo_en_q && rx_cnt != {(AW+1){1'b0}}))) begin
            id_code = `USL_ID_RXDATA;
        end else if (ien_q[1] && thr_irq_q) begin
            id_code = `USL_ID_TXEMPTY;
        end else begin
            id_code = `USL_ID_MODEM;
            pend = ien_q[3] && |hsi_delta_q;
        end
    end
    // Registered read data and pins
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
            irq_o <= 1'b0;
            dtr_n_o <= 1'b1;
            rts_n_o <= 1'b1;
            receive_ready_pin_n_o <= 1'b1;
            transmit_ready_pin_n_o <= 1'b0;
        end else begin
            irq_o <= pend;
            dtr_n_o <= !hso_q[0];
            rts_n_o <= !hso_q[1];
            receive_ready_pin_n_o <= (pin_mode_q && fifo_en_q) ?
                !(rx_cnt >= trig_lvl || timeout_q) :
                (rx_cnt == {(AW+1){1'b0}});
            transmit_ready_pin_n_o <= (pin_mode_q && fifo_en_q) ?
                tx_full : (tx_cnt != {(AW+1){1'b0}});
            case (addr_i)
                `USL_OFF_DATA: rdata_o <= divsel ? div_q[7:0] :
                                          rx_head[7:0];
                `USL_OFF_IEN: rdata_o <= divsel ? div_q[15:8] : ien_q;
                `USL_OFF_FIFO_SETUP: rdata_o <= {{2{fifo_en_q}}, 2'b00,
                                                 id_code[3:1], !pend};
                `USL_OFF_FRAME: rdata_o <= frame_q;
                `USL_OFF_HSO: rdata_o <= hso_q;
                `USL_OFF_LINE: rdata_o <= {
                    fifo_en_q && rx_err_any,
                    tx_cnt == {(AW+1){1'b0}} && tx_st_q == ST_IDLE &&
                        !tx_pop,
                    !tx_full,
                    line_err_q,
                    rx_cnt != {(AW+1){1'b0}}};
                `USL_OFF_HSI: rdata_o <= {hsi_now, hsi_delta_q};
                default: rdata_o <= scratch_q;
            endcase
        end
    end
endmodule

// *** sim/usl_port_assertions.sv ***
// Pin-level assertions for the serial port control block
`timescale 1ns/10ps
module usl_port_assertions (
    input wire clk_i,
    input wire reset_n_i,
    input wire [2:0] addr_i,
    input wire wr_i,
    input wire [7:0] wdata_i,
    input wire [7:0] rdata_o,
    input wire cts_n_i,
    input wire dsr_n_i,
    input wire ri_n_i,
    input wire dcd_n_i,
    input wire txd_o,
    input wire dtr_n_o,
    input wire rts_n_o
);
    reg [7:0] frm_q;
    reg [7:0] hso_q;
    reg [7:0] dll_q;
    reg fen_q;
    reg [3:0] qc_q;
    reg [3:0] sc_q;
    reg [3:0] pin_q;
    wire [3:0] pins = {dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
    wire quiet = qc_q > 4'h1;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Shadows of written registers, cycles since write or pin change
    always @(posedge clk_i) begin
        pin_q <= pins;
        if (!reset_n_i) begin
            frm_q <= 8'h00;
            hso_q <= 8'h00;
            dll_q <= 8'h01;
            fen_q <= 1'b0;
            qc_q <= 4'h0;
            sc_q <= 4'h0;
        end else begin
            qc_q <= wr_i ? 4'h0 : qc_q + {3'h0, qc_q != 4'hF};
            sc_q <= (pins != pin_q) ? 4'h0 : sc_q + {3'h0, sc_q != 4'hF};
            if (wr_i && addr_i == 3'h3) frm_q <= wdata_i;
            if (wr_i && addr_i == 3'h4) hso_q <= wdata_i;
            if (wr_i && addr_i == 3'h2) fen_q <= wdata_i[0];
            if (wr_i && addr_i == 3'h0 && frm_q[7]) dll_q <= wdata_i;
        end
    end
    property p_id_code;
        $past(addr_i) == 3'h2 && quiet |-> rdata_o[5:4] == 2'b00 &&
            rdata_o[3:0] inside {4'h6, 4'h4, 4'hC, 4'h2, 4'h0, 4'h1};
    endproperty
    a_id_code: assert property (p_id_code) else $error("bad id");
    property p_id_fifo;
        $past(addr_i) == 3'h2 && quiet |-> rdata_o[7:6] == {2{fen_q}};
    endproperty
    a_id_fifo: assert property (p_id_fifo) else $error("id fifo");
    property p_frame_rb;
        $past(addr_i) == 3'h3 && quiet |-> rdata_o == frm_q;
    endproperty
    a_frame_rb: assert property (p_frame_rb) else $error("frame");
    property p_hso_rb;
        $past(addr_i) == 3'h4 && quiet |-> rdata_o[4:0] == hso_q[4:0];
    endproperty
    a_hso_rb: assert property (p_hso_rb) else $error("hso");
    property p_div_rb;
        $past(addr_i) == 3'h0 && frm_q[7] && quiet |-> rdata_o == dll_q;
    endproperty
    a_div_rb: assert property (p_div_rb) else $error("divisor");
    property p_hso_pins;
        qc_q > 4'h2 |-> dtr_n_o == !hso_q[0] && rts_n_o == !hso_q[1];
    endproperty
    a_hso_pins: assert property (p_hso_pins) else $error("pins");
    property p_break;
        frm_q[6] && qc_q > 4'h2 |-> !txd_o;
    endproperty
    a_break: assert property (p_break) else $error("break");
    property p_line_temt;
        $past(addr_i) == 3'h5 && rdata_o[6] |-> rdata_o[5];
    endproperty
    a_line_temt: assert property (p_line_temt) else $error("temt");
    property p_msr_lvl;
        $past(addr_i) == 3'h6 && sc_q > 4'h5 |-> rdata_o[7:4] == ~pins;
    endproperty
    a_msr_lvl: assert property (p_msr_lvl) else $error("msr");
endmodule

// *** sim/usl_remote.sv ***
// Remote serial device model with modem status lines
`timescale 1ns/10ps
module usl_remote #(
    parameter BT = 16
) (
    input wire clk_i,
    input wire txd_i,
    output reg rxd_o,
    output reg cts_n_o,
    output reg dsr_n_o,
    output reg ri_n_o,
    output reg dcd_n_o
);
    initial begin
        rxd_o = 1'b1;
        {cts_n_o, dsr_n_o, ri_n_o, dcd_n_o} = 4'hF;
    end
    task automatic send(input logic [7:0] d, input int n, input logic stp);
        int i;
        rxd_o = 1'b0;
        repeat (BT) @(negedge clk_i);
        for (i = 0; i < n; i++) begin
            rxd_o = d[i];
            repeat (BT) @(negedge clk_i);
        end
        rxd_o = stp;
        repeat (BT) @(negedge clk_i);
        rxd_o = 1'b1;
        repeat (2 * BT) @(negedge clk_i);
    endtask
    task automatic recv(output logic [7:0] d, input int n, output logic ok);
        int i;
        d = 8'h00;
        for (i = 0; i < 4000 && txd_i; i++) @(negedge clk_i);
        ok = !txd_i;
        repeat (BT / 2) @(negedge clk_i);
        for (i = 0; i < n; i++) begin
            repeat (BT) @(negedge clk_i);
            d[i] = txd_i;
        end
        repeat (BT) @(negedge clk_i);
    endtask
endmodule

// *** sim/tb_usl_port.sv ***
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
bind usl_port usl_port_assertions chk (.clk_i, .reset_n_i, .addr_i, .wr_i,
    .wdata_i, .rdata_o, .cts_n_i, .dsr_n_i, .ri_n_i, .dcd_n_i, .txd_o,
    .dtr_n_o, .rts_n_o);
module tb_usl_port;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] wdata_i = 8'h00;
    wire [7:0] rdata_o;
    wire irq_o, rxd_i, cts_n_i, dsr_n_i, ri_n_i, dcd_n_i, txd_o, dtr_n_o;
    wire rts_n_o, receive_ready_pin_n_o, transmit_ready_pin_n_o;
    int num_errors = 0;
    int cmp_count = 0;
    int k, i;
    int trg [4] = '{1, 4, 8, 14};
    logic [7:0] d;
    logic ok;
    logic [7:0] rows [11][3] = '{'{7, 8'hA5, 8'hA5}, '{7, 8'h5A, 8'h5A},
        '{4, 8'h13, 8'h13}, '{4, 0, 0}, '{3, 8'h5C, 8'h5C}, '{3, 8'h80, 8'h80},
        '{0, 8'h34, 8'h34}, '{1, 8'h12, 8'h12}, '{0, 1, 1}, '{1, 0, 0},
        '{3, 3, 3}};
    usl_port uut (.clk_i, .reset_n_i, .addr_i, .wr_i, .rd_i, .wdata_i,
        .rdata_o, .irq_o, .rxd_i, .cts_n_i, .dsr_n_i, .ri_n_i, .dcd_n_i,
        .txd_o, .dtr_n_o, .rts_n_o, .receive_ready_pin_n_o,
        .transmit_ready_pin_n_o);
    usl_remote rem (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i),
        .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .ri_n_o(ri_n_i),
        .dcd_n_o(dcd_n_i));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = v;
        wr_i = 1'b1;
        @(negedge clk_i);
        wr_i = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(negedge clk_i);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge clk_i);
        rd_i = 1'b0;
        v = rdata_o;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        cmp(v, e);
    endtask
    task automatic do_reset();
        @(negedge clk_i);
        reset_n_i = 1'b0;
        repeat (12) @(negedge clk_i);
        reset_n_i = 1'b1;
        cmp({3'h0, txd_o, dtr_n_o, rts_n_o, receive_ready_pin_n_o,
            transmit_ready_pin_n_o}, 8'h1E);
        rdc(3'h3, 8'h00);
        rdc(3'h5, 8'h60);
        rdc(3'h2, 8'h01);
    endtask
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        for (k = 0; k < 11; k++) begin
            wr(rows[k][0][2:0], rows[k][1]);
            rdc(rows[k][0][2:0], rows[k][2]);
            repeat (4) @(negedge clk_i);
        end
        // Each word length, both directions, single-character mode
        for (k = 0; k < 4; k++) begin
            wr(3'h3, k[7:0]);
            rem.send(8'h9A, k + 5, 1'b1);
            cmp({7'h0, receive_ready_pin_n_o}, 8'h00);
            rdc(3'h0, 8'h9A & (8'hFF >> (3 - k)));
            fork
                rem.recv(d, k + 5, ok);
                wr(3'h0, 8'hC6);
            join
            cmp(d, 8'hC6 & (8'hFF >> (3 - k)));
            cmp({7'h0, ok}, 8'h01);
        end
        wr(3'h1, 8'h05);
        for (k = 0; k < 4; k++) begin
            wr(3'h2, {k[1:0], 6'h0B});
            for (i = 1; i <= trg[k]; i++) begin
                rem.send(8'h40 + i[7:0], 8, 1'b1);
                rdc(3'h2, i == trg[k] ? 8'hC4 : 8'hC1);
                cmp({7'h0, irq_o}, {7'h0, i == trg[k]});
                cmp({7'h0, receive_ready_pin_n_o}, {7'h0, i != trg[k]});
            end
        end
        rem.send(8'h00, 8, 1'b0);
        rdc(3'h2, 8'hC6);
        rd(3'h5, d);
        cmp(d & 8'hF7, 8'hF1);
        rdc(3'h5, 8'hE1);
        rdc(3'h2, 8'hC4);
        wr(3'h2, 8'h03);
        rdc(3'h5, 8'h60);
        rd(3'h6, d);
        wr(3'h1, 8'h08);
        rem.ri_n_o = 1'b0;
        repeat (8) @(negedge clk_i);
        rem.ri_n_o = 1'b1;
        rem.dcd_n_o = 1'b0;
        rem.cts_n_o = 1'b0;
        repeat (8) @(negedge clk_i);
        rdc(3'h2, 8'hC0);
        rdc(3'h6, 8'h9D);
        rdc(3'h6, 8'h90);
        wr(3'h1, 8'h00);
        fork
            rem.recv(d, 8, ok);
            begin
                wr(3'h0, 8'h11);
                wr(3'h0, 8'h22);
                wr(3'h0, 8'h33);
                rdc(3'h5, 8'h20);
                wr(3'h2, 8'h05);
            end
        join
        cmp(d, 8'h11);
        rem.recv(d, 8, ok);
        cmp({7'h0, ok}, 8'h00);
        rdc(3'h5, 8'h60);
        wr(3'h3, 8'h1A);
        rem.send(8'h01, 8, 1'b1);
        rdc(3'h5, 8'hE5);
        do_reset();
        end_of_test();
    end
endmodule
